// *** pcm_map.svh ***
// Constants of the serial PCM port: word layout, slot positions and timing counts.
// Included by the package; holds definitions only.
`ifndef PCM_MAP_SVH
`define PCM_MAP_SVH
`define PCM_WORD_W 8
`define PCM_FIFO_DEPTH 16
`define PCM_FIFO_AW 4
// Falling edge (counted from the sync edge) that samples the sign bit
`define PCM_START_LONG 5'h00
`define PCM_START_SHORT 5'h01
`define PCM_START_B1 5'h01
`define PCM_START_B2 5'h0b
`define PCM_LAST_OFS 5'h07
// Code sent when the transmit FIFO has no sample
`define PCM_IDLE_CODE 8'hff
// Times in ns; half periods derived in cycles of ref_clk, frame length in bit periods
`define PCM_CLK_NS 10
`define PCM_FRAME_NS 125000
`define PCM_BCLK_NS 500
`define PCM_MCLK_NS 480
`define PCM_BCLK_HALF (`PCM_BCLK_NS / (2 * `PCM_CLK_NS))
`define PCM_MCLK_HALF (`PCM_MCLK_NS / (2 * `PCM_CLK_NS))
`define PCM_FRAME_BITS (`PCM_FRAME_NS / `PCM_BCLK_NS)
`define PCM_LONG_FS_BITS 8
`endif

// *** pcm_pkg.sv ***
// Types shared by both ends of the serial PCM port.
// Assumes pcm_map.svh is on the include path.
`include "pcm_map.svh"
package pcm_pkg;
	typedef enum logic [1:0] {MODE_LONG, MODE_SHORT, MODE_LINK} pcm_mode_e;
	typedef enum logic {SLOT_FIRST, SLOT_SECOND} pcm_slot_e;
	typedef enum logic [1:0] {TX_IDLE, TX_RUN, TX_HOLD} pcm_tx_e;
	typedef logic [`PCM_WORD_W-1:0] pcm_word_t;

	// Falling edge after the sync edge that carries the sign bit
	function automatic logic [4:0] pcm_start(input pcm_mode_e m, input pcm_slot_e s);
		if (m == MODE_LONG) begin
			return `PCM_START_LONG;
		end else if (m == MODE_SHORT) begin
			return `PCM_START_SHORT;
		end else begin
			return (s == SLOT_SECOND) ? `PCM_START_B2 : `PCM_START_B1;
		end
	endfunction : pcm_start
endpackage : pcm_pkg

// *** pcm_if.sv ***
// Pins between the codec end and the highway controller end.
// Shared transmit lines idle high when nobody drives them.
`timescale 1ns/10ps
interface pcm_if;
	logic master_clock;
	logic tx_bit_clock;
	logic rx_bit_clock;
	logic tx_frame_sync;
	logic rx_frame_sync;
	logic rx_serial_data;
	logic tx_data_o;
	logic tx_data_oe;
	logic tx_serial_data;
	logic link_clock;
	logic link_sync;
	logic link_rx_data;
	logic link_tx_o;
	logic link_tx_oe;
	logic link_tx_data;

	// Resolved line levels
	assign tx_serial_data = tx_data_oe ? tx_data_o : 1'b1;
	assign link_tx_data = link_tx_oe ? link_tx_o : 1'b1;

	modport dev (
		input master_clock, tx_bit_clock, rx_bit_clock, tx_frame_sync, rx_frame_sync, rx_serial_data,
		input link_clock, link_sync, link_rx_data,
		output tx_data_o, tx_data_oe, link_tx_o, link_tx_oe
	);
	modport host (
		output master_clock, tx_bit_clock, rx_bit_clock, tx_frame_sync, rx_frame_sync, rx_serial_data,
		output link_clock, link_sync, link_rx_data,
		input tx_serial_data, link_tx_data
	);
endinterface : pcm_if

// *** pcm_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and registered flags.
// Assumes one clock; ce freezes it.
`timescale 1ns/10ps
module pcm_fifo #(
	parameter int W = `PCM_WORD_W,
	parameter int DEPTH = `PCM_FIFO_DEPTH,
	parameter int AW = `PCM_FIFO_AW
) (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Asynchronous reset, high
	input wire logic ce, // Clock enable
	input wire logic [W-1:0] in_data, // Write word
	input wire logic in_valid, // Write request
	output logic in_ready, // Room for a word
	output logic [W-1:0] out_data, // Head word
	output logic out_valid, // Head word present
	input wire logic out_ready // Head word taken
);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic [AW:0] cnt_nxt;
	logic push;
	logic pop;

	// Handshakes and next fill level
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rp_r];
	always_comb begin
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// Storage
	always_ff @(posedge ref_clk) begin
		if (ce && push) begin
			mem[wp_r] <= in_data;
		end
	end

	// Pointers and flags
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else if (ce) begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			cnt_r <= cnt_nxt;
			in_ready <= (cnt_nxt != DEPTH[AW:0]);
			out_valid <= (cnt_nxt != '0);
		end
	end
endmodule : pcm_fifo

// *** pcm_dev.sv ***
// Codec end of the serial PCM port: long frame, short frame and link framing.
// Assumes the far end makes all bit clocks and syncs; they are sampled on ref_clk.
`timescale 1ns/10ps
module pcm_dev (
	input wire logic ref_clk, // 100 MHz clock
	input wire logic rst, // Asynchronous reset, high
	input wire logic ce, // Clock enable
	input wire pcm_pkg::pcm_mode_e mode, // Framing mode
	input wire pcm_pkg::pcm_slot_e slot, // Bearer slot in link mode
	input wire logic [`PCM_WORD_W-1:0] wr_data, // Sample to send
	input wire logic wr_valid, // Sample offered
	output logic wr_ready, // FIFO has room
	output logic [`PCM_WORD_W-1:0] rd_data, // Received sample
	output logic rd_valid, // Received sample pulse
	pcm_if.dev lnk // Serial pins
);
	logic link_m;
	logic [4:0] raw;
	logic [4:0] s1_r;
	logic [4:0] s2_r;
	logic [1:0] s3_r;
	logic t_fs_d_r;
	logic t_clk;
	logic t_fs;
	logic r_clk;
	logic r_fs;
	logic r_dat;
	logic t_rise;
	logic t_fall;
	logic r_fall;
	logic [4:0] start;
	logic [4:0] last;
	logic [`PCM_WORD_W-1:0] f_data;
	logic f_valid;
	logic f_take;
	logic r_act_r;
	logic r_arm_r;
	logic [4:0] r_cnt_r;
	logic [4:0] r_idx;
	logic [`PCM_WORD_W-1:0] r_sh_r;
	pcm_pkg::pcm_tx_e t_st_r;
	logic t_arm_r;
	logic [4:0] t_cnt_r;
	logic [4:0] t_k;
	logic [`PCM_WORD_W-1:0] t_word_r;
	logic t_load;
	logic t_long_go;
	logic t_oe_r;
	logic t_out_r;

	// Pin selection per framing; link mode uses one clock and sync both ways
	assign link_m = (mode == pcm_pkg::MODE_LINK);
	assign raw[0] = link_m ? lnk.link_clock : lnk.tx_bit_clock;
	assign raw[1] = link_m ? lnk.link_sync : lnk.tx_frame_sync;
	assign raw[2] = link_m ? lnk.link_clock : lnk.rx_bit_clock;
	assign raw[3] = link_m ? lnk.link_sync : lnk.rx_frame_sync;
	assign raw[4] = link_m ? lnk.link_rx_data : lnk.rx_serial_data;

	// Two-stage synchroniser, third stage only for edge finding
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			t_fs_d_r <= 1'b0;
		end else if (ce) begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= {s2_r[2], s2_r[0]};
			t_fs_d_r <= s2_r[1];
		end
	end

	// Edges of the sampled clocks
	assign t_clk = s2_r[0];
	assign t_fs = s2_r[1];
	assign r_clk = s2_r[2];
	assign r_fs = s2_r[3];
	assign r_dat = s2_r[4];
	assign t_rise = t_clk && !s3_r[0];
	assign t_fall = !t_clk && s3_r[0];
	assign r_fall = !r_clk && s3_r[1];
	assign start = pcm_pkg::pcm_start(mode, slot);
	assign last = start + `PCM_LAST_OFS;

	// Transmit sample buffer
	pcm_fifo #(.W(`PCM_WORD_W), .DEPTH(`PCM_FIFO_DEPTH), .AW(`PCM_FIFO_AW)) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.in_data(wr_data),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_take)
	);

	// Receive bit index: sync fall is 0, later falls count up
	assign r_idx = r_act_r ? r_cnt_r + 5'h01 : 5'h00;

	// Receive framing and shift register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			r_act_r <= 1'b0;
			r_arm_r <= 1'b0;
			r_cnt_r <= '0;
			r_sh_r <= '0;
			rd_data <= '0;
			rd_valid <= 1'b0;
		end else if (ce) begin
			rd_valid <= 1'b0;
			// Arm on any low sync so the first frame after reset is taken
			if (!r_fs) begin
				r_arm_r <= 1'b1;
			end
			if (r_fall && (r_act_r || (r_fs && r_arm_r))) begin
				if (!r_act_r) begin
					r_arm_r <= 1'b0;
				end
				if (r_idx >= start && r_idx <= last) begin
					r_sh_r <= {r_sh_r[`PCM_WORD_W-2:0], r_dat};
				end
				if (r_idx == last) begin
					r_act_r <= 1'b0;
					rd_data <= {r_sh_r[`PCM_WORD_W-2:0], r_dat};
					rd_valid <= 1'b1;
				end else begin
					r_act_r <= 1'b1;
					r_cnt_r <= r_idx;
				end
			end
		end
	end

	// Frame start: long frame launches at later of sync rise and clock rise
	assign t_long_go = (t_rise && t_fs) || (t_fs && !t_fs_d_r && t_clk);
	assign t_load = (t_st_r == pcm_pkg::TX_IDLE) && t_arm_r &&
		((mode == pcm_pkg::MODE_LONG) ? t_long_go : (t_fall && t_fs));
	assign f_take = ce && t_load;
	assign t_k = t_cnt_r + 5'h01 - start;

	// Transmit sequencer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			t_st_r <= pcm_pkg::TX_IDLE;
			t_arm_r <= 1'b0;
			t_cnt_r <= '0;
			t_word_r <= '0;
			t_oe_r <= 1'b0;
			t_out_r <= 1'b1;
		end else if (ce) begin
			if (!t_fs) begin
				t_arm_r <= 1'b1;
			end
			unique case (t_st_r)
				pcm_pkg::TX_IDLE: begin
					if (t_load) begin
						t_arm_r <= 1'b0;
						t_word_r <= f_valid ? f_data : `PCM_IDLE_CODE;
						t_st_r <= pcm_pkg::TX_RUN;
						if (mode == pcm_pkg::MODE_LONG) begin
							t_cnt_r <= 5'h1f;
							t_out_r <= f_valid ? f_data[`PCM_WORD_W-1] : 1'b1;
							t_oe_r <= 1'b1;
						end else begin
							t_cnt_r <= 5'h00;
						end
					end
				end
				pcm_pkg::TX_RUN: begin
					if (t_rise && t_k <= `PCM_LAST_OFS) begin
						t_out_r <= t_word_r[3'(`PCM_LAST_OFS - t_k)];
						t_oe_r <= 1'b1;
					end
					if (t_fall) begin
						t_cnt_r <= t_cnt_r + 5'h01;
						if (t_cnt_r + 5'h01 == last) begin
							if (mode == pcm_pkg::MODE_LONG && t_fs) begin
								t_st_r <= pcm_pkg::TX_HOLD;
							end else begin
								t_oe_r <= 1'b0;
								t_st_r <= pcm_pkg::TX_IDLE;
							end
						end
					end
				end
				pcm_pkg::TX_HOLD: begin
					if (!t_fs) begin
						t_oe_r <= 1'b0;
						t_st_r <= pcm_pkg::TX_IDLE;
					end
				end
				default: begin
					t_st_r <= pcm_pkg::TX_IDLE;
				end
			endcase
		end
	end

	// Pin drivers; only the pin of the current framing is enabled
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lnk.tx_data_o <= 1'b1;
			lnk.tx_data_oe <= 1'b0;
			lnk.link_tx_o <= 1'b1;
			lnk.link_tx_oe <= 1'b0;
		end else if (ce) begin
			lnk.tx_data_o <= t_out_r;
			lnk.tx_data_oe <= t_oe_r && !link_m;
			lnk.link_tx_o <= t_out_r;
			lnk.link_tx_oe <= t_oe_r && link_m;
		end
	end
endmodule : pcm_dev

// *** pcm_host.sv ***
// Highway controller end: makes master clock, bit clock and syncs by division of ref_clk.
// Assumes the codec end samples its pins on its own clock.
`timescale 1ns/10ps
module pcm_host #(
	parameter int FRAME_BITS = `PCM_FRAME_BITS // Bit periods per 125 us frame
) (
	input wire logic ref_clk, // 100 MHz clock
	input wire logic rst, // Asynchronous reset, high
	input wire logic ce, // Clock enable
	input wire pcm_pkg::pcm_mode_e mode, // Framing mode
	input wire pcm_pkg::pcm_slot_e slot, // Bearer slot in link mode
	input wire logic [`PCM_WORD_W-1:0] in_word, // Sample to send to the codec
	output logic in_take, // Sample latched pulse
	output logic [`PCM_WORD_W-1:0] out_word, // Sample from the codec
	output logic out_valid, // Sample pulse
	pcm_if.host lnk // Serial pins
);
	logic [7:0] bc_r;
	logic [7:0] mc_r;
	logic bclk_r;
	logic mclk_r;
	logic [8:0] bit_r;
	logic [8:0] bit_nxt;
	logic rise;
	logic fall;
	logic fs_r;
	logic dat_r;
	logic [`PCM_WORD_W-1:0] word_r;
	logic [`PCM_WORD_W-1:0] sh_r;
	logic [1:0] in_s_r;
	logic [4:0] start;
	logic [8:0] k_nxt;
	logic [8:0] k_cur;

	assign rise = (bc_r == 8'(`PCM_BCLK_HALF - 1)) && !bclk_r;
	assign fall = (bc_r == 8'(`PCM_BCLK_HALF - 1)) && bclk_r;
	assign bit_nxt = (bit_r == 9'(FRAME_BITS - 1)) ? 9'h000 : bit_r + 9'h001;
	assign start = pcm_pkg::pcm_start(mode, slot);
	assign k_nxt = bit_nxt - {4'h0, start};
	assign k_cur = bit_r - {4'h0, start};

	// Clock dividers for master and bit clocks
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bc_r <= '0;
			mc_r <= '0;
			bclk_r <= 1'b0;
			mclk_r <= 1'b0;
		end else if (ce) begin
			bc_r <= (bc_r == 8'(`PCM_BCLK_HALF - 1)) ? 8'h00 : bc_r + 8'h01;
			if (bc_r == 8'(`PCM_BCLK_HALF - 1)) begin
				bclk_r <= !bclk_r;
			end
			mc_r <= (mc_r == 8'(`PCM_MCLK_HALF - 1)) ? 8'h00 : mc_r + 8'h01;
			if (mc_r == 8'(`PCM_MCLK_HALF - 1)) begin
				mclk_r <= !mclk_r;
			end
		end
	end

	// Frame position, sync and outgoing data change on the rising edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bit_r <= 9'(FRAME_BITS - 1);
			fs_r <= 1'b0;
			dat_r <= 1'b1;
			word_r <= '0;
			in_take <= 1'b0;
		end else if (ce) begin
			in_take <= 1'b0;
			if (rise) begin
				bit_r <= bit_nxt;
				fs_r <= (mode == pcm_pkg::MODE_LONG) ? (bit_nxt < 9'(`PCM_LONG_FS_BITS)) : (bit_nxt == 9'h000);
				if (bit_nxt == 9'h000) begin
					word_r <= in_word;
					in_take <= 1'b1;
				end
				if (k_nxt <= 9'(`PCM_LAST_OFS)) begin
					dat_r <= (bit_nxt == 9'h000) ? in_word[`PCM_WORD_W-1] : word_r[3'(`PCM_LAST_OFS - k_nxt[4:0])];
				end else begin
					dat_r <= 1'b1;
				end
			end
		end
	end

	// Codec transmit pin through two flip-flops, sampled at the falling edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			in_s_r <= 2'b11;
			sh_r <= '0;
			out_word <= '0;
			out_valid <= 1'b0;
		end else if (ce) begin
			in_s_r <= {in_s_r[0], (mode == pcm_pkg::MODE_LINK) ? lnk.link_tx_data : lnk.tx_serial_data};
			out_valid <= 1'b0;
			if (fall && k_cur <= 9'(`PCM_LAST_OFS)) begin
				sh_r <= {sh_r[`PCM_WORD_W-2:0], in_s_r[1]};
				if (k_cur == 9'(`PCM_LAST_OFS)) begin
					out_word <= {sh_r[`PCM_WORD_W-2:0], in_s_r[1]};
					out_valid <= 1'b1;
				end
			end
		end
	end

	// Pins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lnk.master_clock <= 1'b0;
			lnk.tx_bit_clock <= 1'b0;
			lnk.rx_bit_clock <= 1'b0;
			lnk.link_clock <= 1'b0;
			lnk.tx_frame_sync <= 1'b0;
			lnk.rx_frame_sync <= 1'b0;
			lnk.link_sync <= 1'b0;
			lnk.rx_serial_data <= 1'b1;
			lnk.link_rx_data <= 1'b1;
		end else if (ce) begin
			lnk.master_clock <= mclk_r;
			lnk.tx_bit_clock <= bclk_r;
			lnk.rx_bit_clock <= bclk_r;
			lnk.link_clock <= bclk_r;
			lnk.tx_frame_sync <= fs_r && (mode != pcm_pkg::MODE_LINK);
			lnk.rx_frame_sync <= fs_r && (mode != pcm_pkg::MODE_LINK);
			lnk.link_sync <= fs_r && (mode == pcm_pkg::MODE_LINK);
			lnk.rx_serial_data <= dat_r;
			lnk.link_rx_data <= dat_r;
		end
	end
endmodule : pcm_host

// *** pcm_port_checker.sv ***
// Assertion checker for the serial PCM pins between the codec end and the highway end.
// Assumes host pins change on ref_clk edges with a bit period of 2 * PCM_BCLK_HALF cycles.
`timescale 1ns/10ps
module pcm_port_checker #(
	parameter int FRAME_BITS = `PCM_FRAME_BITS // Bit periods per frame
) (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Reset, high
	input wire logic tx_bit_clock, // Transmit bit clock
	input wire logic rx_bit_clock, // Receive bit clock
	input wire logic tx_frame_sync, // Frame sync
	input wire logic rx_serial_data, // Host data to codec
	input wire logic tx_data_o, // Codec data
	input wire logic tx_data_oe, // Codec drive enable
	input wire logic link_clock, // Link clock
	input wire logic link_sync, // Link sync
	input wire logic link_rx_data, // Host link data
	input wire logic link_tx_oe // Codec link drive enable
);
	localparam int PERIOD = FRAME_BITS * 2 * `PCM_BCLK_HALF;
	logic [9:0] oe_run_r;
	logic [9:0] lk_run_r;
	logic [9:0] fs_run_r;
	logic [15:0] fr_cnt_r;
	logic sync_q_r;
	logic fr_seen_r;
	wire logic sync_rise = (tx_frame_sync | link_sync) & ~sync_q_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Length of each drive window and sync pulse
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			oe_run_r <= '0;
			lk_run_r <= '0;
			fs_run_r <= '0;
		end else begin
			oe_run_r <= tx_data_oe ? oe_run_r + 10'h001 : 10'h000;
			lk_run_r <= link_tx_oe ? lk_run_r + 10'h001 : 10'h000;
			fs_run_r <= tx_frame_sync ? fs_run_r + 10'h001 : 10'h000;
		end
	end
	// Cycles since the last frame start
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fr_cnt_r <= '0;
			sync_q_r <= 1'b0;
			fr_seen_r <= 1'b0;
		end else begin
			sync_q_r <= tx_frame_sync | link_sync;
			fr_cnt_r <= sync_rise ? 16'h0001 : fr_cnt_r + 16'h0001;
			fr_seen_r <= fr_seen_r | sync_rise;
		end
	end
	sequence s_frame_start;
		sync_rise && fr_seen_r;
	endsequence
	sequence s_tx_release;
		$fell(tx_data_oe);
	endsequence
	a_tx_drive_rise: assert property ($rose(tx_data_oe) |-> tx_bit_clock)
		else $error("Codec drive began while bit clock low");
	a_tx_bit_rise: assert property (tx_data_oe && $past(tx_data_oe) && $changed(tx_data_o) |-> tx_bit_clock)
		else $error("Codec bit changed while bit clock low");
	a_tx_release_fall: assert property (s_tx_release |-> !tx_frame_sync && (!tx_bit_clock || $past(tx_frame_sync, 6)))
		else $error("Codec release not after clock fall or sync fall");
	a_tx_drive_span: assert property (s_tx_release |-> oe_run_r >= 10'd370 && oe_run_r <= 10'd405)
		else $error("Codec drive window length wrong");
	a_link_drive_rise: assert property ($rose(link_tx_oe) |-> link_clock)
		else $error("Link drive began while link clock low");
	a_link_release: assert property ($fell(link_tx_oe) |-> !link_clock && lk_run_r >= 10'd370 && lk_run_r <= 10'd380)
		else $error("Link release timing or slot length wrong");
	a_rx_data_rise: assert property ($changed(rx_serial_data) |-> rx_bit_clock)
		else $error("Receive data changed near a sampling fall");
	a_link_rx_rise: assert property ($changed(link_rx_data) |-> link_clock)
		else $error("Link data changed near a sampling fall");
	a_sync_on_rise: assert property ($changed(tx_frame_sync) |-> tx_bit_clock)
		else $error("Frame sync changed near a sampling fall");
	a_link_sync_rise: assert property ($changed(link_sync) |-> link_clock)
		else $error("Link sync changed near a sampling fall");
	a_sync_width: assert property ($fell(tx_frame_sync) |-> fs_run_r <= 10'd50 || fs_run_r >= 10'd100)
		else $error("Frame sync width between short and long framing");
	a_frame_period: assert property (s_frame_start |-> fr_cnt_r == PERIOD)
		else $error("Frame start spacing wrong");
endmodule : pcm_port_checker

// *** pcm_serial_port_timing_bench.sv ***
// Bench: codec end and highway end joined by the pin interface, each framing in turn.
// Assumes pcm_pkg and pcm_map.svh; the frame is shortened to 24 bit periods.
`timescale 1ns/10ps
module pcm_serial_port_timing_bench;
	localparam int FB = 24;
	localparam int FRAME = FB * 2 * `PCM_BCLK_HALF;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	pcm_pkg::pcm_mode_e mode = pcm_pkg::MODE_SHORT;
	pcm_pkg::pcm_slot_e slot = pcm_pkg::SLOT_FIRST;
	pcm_pkg::pcm_word_t wr_data = 8'h00;
	logic wr_valid = 1'b0;
	logic wr_ready;
	pcm_pkg::pcm_word_t rd_data;
	logic rd_valid;
	pcm_pkg::pcm_word_t in_word = 8'h00;
	logic in_take;
	pcm_pkg::pcm_word_t out_word;
	logic out_valid;
	pcm_pkg::pcm_word_t txq[$];
	pcm_pkg::pcm_word_t rxq[$];
	pcm_pkg::pcm_word_t tx_exp;
	pcm_pkg::pcm_word_t rx_exp;
	pcm_pkg::pcm_word_t wire_sh = 8'h00;
	int n_mismatch = 0;
	int n_checks = 0;
	int cycles = 0;
	pcm_if u_pcm_if();
	pcm_dev u_pcm_dev(.ref_clk(ref_clk), .rst(rst), .ce(ce), .mode(mode), .slot(slot), .wr_data(wr_data),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .lnk(u_pcm_if.dev));
	pcm_host #(.FRAME_BITS(FB)) u_pcm_host(.ref_clk(ref_clk), .rst(rst), .ce(ce), .mode(mode), .slot(slot),
		.in_word(in_word), .in_take(in_take), .out_word(out_word), .out_valid(out_valid), .lnk(u_pcm_if.host));
	pcm_port_checker #(.FRAME_BITS(FB)) u_pcm_port_checker(.ref_clk(ref_clk), .rst(rst),
		.tx_bit_clock(u_pcm_if.tx_bit_clock), .rx_bit_clock(u_pcm_if.rx_bit_clock),
		.tx_frame_sync(u_pcm_if.tx_frame_sync), .rx_serial_data(u_pcm_if.rx_serial_data),
		.tx_data_o(u_pcm_if.tx_data_o), .tx_data_oe(u_pcm_if.tx_data_oe), .link_clock(u_pcm_if.link_clock),
		.link_sync(u_pcm_if.link_sync), .link_rx_data(u_pcm_if.link_rx_data), .link_tx_oe(u_pcm_if.link_tx_oe));
	wire logic w_link = (mode == pcm_pkg::MODE_LINK);
	wire logic w_clk = w_link ? u_pcm_if.link_clock : u_pcm_if.tx_bit_clock;
	wire logic w_oe = w_link ? u_pcm_if.link_tx_oe : u_pcm_if.tx_data_oe;
	wire logic w_dat = w_link ? u_pcm_if.link_tx_data : u_pcm_if.tx_serial_data;
	// Clock
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// Shift in the codec's line at each clock fall while it drives
	always @(negedge w_clk) if (w_oe === 1'b1) wire_sh <= {wire_sh[6:0], w_dat};
	// Compare the line word once the codec has let go, after its last bit
	always @(negedge w_oe) begin
		if (!rst) begin
			check("line word", wire_sh, tx_exp);
		end
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict
	// Offer one word to the codec FIFO; entered and left just after a rising edge
	task automatic wr(input pcm_pkg::pcm_word_t w);
		int k;
		k = 0;
		wr_data <= w;
		wr_valid <= 1'b1;
		@(negedge ref_clk);
		while (wr_ready !== 1'b1 && k < 40) begin
			k++;
			@(negedge ref_clk);
		end
		check("write ready", {7'h00, wr_ready}, 8'h01);
		txq.push_back(w);
		@(posedge ref_clk);
	endtask : wr
	// Reset into one framing, load nw words after the first idle frame, then let them drain
	task automatic run(input pcm_pkg::pcm_mode_e m, input pcm_pkg::pcm_slot_e s, input int nw);
		int k;
		rst <= 1'b1;
		mode <= m;
		slot <= s;
		txq.delete();
		rxq.delete();
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		k = 0;
		@(posedge ref_clk);
		while (out_valid !== 1'b1 && k < 2 * FRAME) begin
			k++;
			@(posedge ref_clk);
		end
		for (int i = 0; i < nw; i++) wr(8'h30 + 8'(i));
		wr_valid <= 1'b0;
		if (nw == `PCM_FIFO_DEPTH) begin
			repeat (2) @(negedge ref_clk);
			check("full ready", {7'h00, wr_ready}, 8'h00);
			@(posedge ref_clk);
			wr_data <= 8'h99;
			wr_valid <= 1'b1;
			repeat (3) @(negedge ref_clk);
			check("refused ready", {7'h00, wr_ready}, 8'h00);
			@(posedge ref_clk);
			wr_valid <= 1'b0;
		end
		repeat ((nw + 2) * FRAME) @(posedge ref_clk);
		check("words left", 8'(txq.size()), 8'h00);
	endtask : run
	// Score words at both user sides, feed the host, and cut a hang short
	always @(posedge ref_clk) begin
		if (!rst && out_valid === 1'b1) begin
			tx_exp = txq.size() ? txq.pop_front() : `PCM_IDLE_CODE;
			check("host word", out_word, tx_exp);
		end
		if (!rst && in_take === 1'b1) begin
			rxq.push_back(in_word);
			in_word <= in_word + 8'h35;
		end
		if (!rst && rd_valid === 1'b1) begin
			rx_exp = rxq.size() ? rxq.pop_front() : 8'hxx;
			check("codec word", rd_data, rx_exp);
		end
		cycles++;
		if (cycles == 70000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	// Every framing and both bearer slots
	initial begin
		run(pcm_pkg::MODE_SHORT, pcm_pkg::SLOT_FIRST, `PCM_FIFO_DEPTH);
		run(pcm_pkg::MODE_LONG, pcm_pkg::SLOT_FIRST, 3);
		run(pcm_pkg::MODE_LINK, pcm_pkg::SLOT_FIRST, 3);
		run(pcm_pkg::MODE_LINK, pcm_pkg::SLOT_SECOND, 3);
		print_verdict();
	end
endmodule : pcm_serial_port_timing_bench
